/* bench/t1_receive_info_status_flags_test.sv */
`timescale 1ns/1ps
`include "t1ri_defs.svh"

module t1_receive_info_status_flags_test;
	import t1ri_pkg::*;
	localparam int DEPTH = 32;
	localparam logic [7:0] A1 = `T1RI_ADDR_INFO1;
	localparam logic [7:0] A2 = `T1RI_ADDR_INFO2;
	localparam logic [7:0] A3 = `T1RI_ADDR_INFO3;
	logic       ref_clk     = 1'b0;
	logic       rst_n       = 1'b0;
	t1ri_host_t host_req;
	logic [7:0] read_data;
	t1ri_evt_t  evt         = '0;
	logic [1:0] rx_level    = 2'b00;
	logic [7:0] jitter_fill = 8'h00;
	logic       pos_in      = 1'b0;
	logic       neg_in      = 1'b0;
	logic       rx_clk      = 1'b0;
	logic       pol         = 1'b0;
	logic [7:0] got;
	int         miscompares = 0;
	int         checked     = 0;
	// expected byte per event, msb event first
	logic [7:0] exp_tab [10] = '{8'h80, 8'h10, 8'h08, 8'h01, 8'h80,
		8'h28, 8'h18, 8'h04, 8'h02, 8'h01};

	// 50 mhz reference
	initial forever #10 ref_clk = ~ref_clk;

	t1ri_info_regs #(.JA_DEPTH(DEPTH), .JA_W(8)) DUT
	(
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.host_req         (host_req),
		.read_data        (read_data),
		.evt              (evt),
		.rx_level         (rx_level),
		.jitter_fill      (jitter_fill),
		.rx_bipolar_pos_in(pos_in),
		.rx_bipolar_neg_in(neg_in),
		.rx_clock_in      (rx_clk)
	);

	t1ri_host_model host
	(
		.ref_clk  (ref_clk),
		.host_req (host_req),
		.read_data(read_data)
	);

	task automatic final_report;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// write mask, read back, compare selected bits
	task automatic snap(input logic [7:0] a, m, sel, e);
		host.write_reg(a, m);
		host.read_reg(a, got);
		checked++;
		if ((got & sel) !== e)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time,
				got & sel, e);
		end
	endtask

	// one line bit, ones alternate rails
	task automatic line_bit(input logic b);
		@(posedge ref_clk);
		pos_in <= b & ~pol;
		neg_in <= b & pol;
		pol = pol ^ b;
		repeat (16) @(posedge ref_clk);
		rx_clk <= 1'b1;
		repeat (16) @(posedge ref_clk);
		rx_clk <= 1'b0;
	endtask

	task automatic bits(input logic b, input int n);
		repeat (n) line_bit(b);
	endtask

	// main sequence
	initial
	begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		snap(A1, 8'hff, 8'hff, 8'h00);
		snap(8'h55, 8'hff, 8'hff, 8'h00);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge ref_clk);
			evt <= t1ri_evt_t'(10'h200 >> i);
			@(posedge ref_clk);
			evt <= '0;
			repeat (5) @(posedge ref_clk);
			snap(i < 4 ? A1 : A2, 8'hff, 8'hff, exp_tab[i]);
			snap(i < 4 ? A1 : A2, 8'hff, 8'hff, 8'h00);
		end
		@(posedge ref_clk);
		evt <= t1ri_evt_t'(10'h021);
		@(posedge ref_clk);
		evt <= '0;
		snap(A2, 8'h01, 8'hff, 8'h01);
		snap(A2, 8'h80, 8'hff, 8'h81);
		snap(A2, 8'hff, 8'hff, 8'h00);
		// every level code, jitter near limit on even codes
		for (int c = 0; c < 4; c++)
		begin
			@(posedge ref_clk);
			rx_level <= c[1:0];
			jitter_fill <= c[0] ? 8'(DEPTH - 5) : 8'(DEPTH - 4);
			repeat (5) @(posedge ref_clk);
			snap(A3, 8'hff, 8'h00, 8'h00);
			snap(A3, 8'hff, 8'hf0, {c[1:0], ~c[0], 5'h10});
		end
		bits(1'b1, 4);
		snap(A1, 8'hff, 8'h00, 8'h00);
		snap(A3, 8'hff, 8'h00, 8'h00);
		bits(1'b0, 7);
		bits(1'b1, 1);
		snap(A1, 8'hff, 8'h60, 8'h00);
		bits(1'b0, 8);
		bits(1'b1, 1);
		snap(A1, 8'hff, 8'h60, 8'h40);
		bits(1'b0, 16);
		bits(1'b1, 1);
		snap(A1, 8'hff, 8'h60, 8'h60);
		repeat (60) @(posedge ref_clk);
		snap(A3, 8'hff, 8'h10, 8'h00);
		repeat (150) @(posedge ref_clk);
		snap(A3, 8'hff, 8'h10, 8'h10);
		bits(1'b0, 191);
		bits(1'b1, 1);
		snap(A3, 8'hff, 8'h08, 8'h00);
		bits(1'b0, 192);
		snap(A3, 8'hff, 8'h08, 8'h08);
		bits(1'b1, 13);
		bits(1'b0, 99);
		snap(A2, 8'hff, 8'h40, 8'h00);
		snap(A3, 8'hff, 8'h08, 8'h08);
		bits(1'b1, 14);
		snap(A2, 8'hff, 8'h40, 8'h40);
		snap(A3, 8'hff, 8'h00, 8'h00);
		snap(A3, 8'hff, 8'h08, 8'h00);
		final_report;
	end

	// cut a hang short
	initial
	begin
		repeat (100000) @(posedge ref_clk);
		miscompares++;
		final_report;
	end
endmodule // t1_receive_info_status_flags_test

/* bench/t1ri_host_model.sv */
`timescale 1ns/1ps
`include "t1ri_defs.svh"

module t1ri_host_model
(
	input  wire logic            ref_clk,
	output t1ri_pkg::t1ri_host_t host_req,
	input  wire logic [7:0]      read_data
);
	import t1ri_pkg::*;

	// bus idles with both strobes low
	initial host_req = '0;

	// mask byte picks which bits refresh
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		host_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge ref_clk);
		host_req.wr <= 1'b0;
	endtask

	// read byte lands one edge after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		host_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge ref_clk);
		host_req.rd <= 1'b0;
		@(posedge ref_clk);
		#1 d = read_data;
		if (a == `T1RI_ADDR_INFO3)
			d[2:0] = 3'b000;
	endtask
endmodule // t1ri_host_model

/* hw/t1ri_defs.svh */
`ifndef T1RI_DEFS_SVH
`define T1RI_DEFS_SVH

// register addresses on the parallel control port
`define T1RI_ADDR_INFO1 8'h22
`define T1RI_ADDR_INFO2 8'h31
`define T1RI_ADDR_INFO3 8'h10
`define T1RI_RESET_BYTE 8'h00
`define T1RI_UNMAPPED   8'h00

// bit positions, information register one
`define T1RI_I1_FRAME_ALIGN  7
`define T1RI_I1_ZERO8        6
`define T1RI_I1_ZERO16       5
`define T1RI_I1_FRAME_BITERR 0
// bit positions, information register two
`define T1RI_I2_SYNC_REGAIN  7
`define T1RI_I2_CARRIER_BACK 6
`define T1RI_I2_TX_SLIP      3
// bit positions, information register three
`define T1RI_I3_JITTER_LIMIT 5
`define T1RI_I3_CLOCK_LOST   4
`define T1RI_I3_CARRIER_LOSS 3

// zero run and carrier criteria, in bit positions
`define T1RI_ZERO_SHORT   8'h08
`define T1RI_ZERO_LONG    8'h10
`define T1RI_LOSS_ZEROS   8'hc0
`define T1RI_CLEAR_ONES   8'h0e
`define T1RI_CLEAR_WINDOW 8'h70

// jitter attenuator margin, in bits
`define T1RI_JA_MARGIN 4

// timing: clock period and least receive clock idle time
`define T1RI_CLK_NS       20
`define T1RI_RX_CLOCK_LOST_MIN_NS  2000
`define T1RI_RX_CLOCK_LOST_CYC \
	((`T1RI_RX_CLOCK_LOST_MIN_NS + `T1RI_CLK_NS - 1) / `T1RI_CLK_NS)

`endif

/* hw/t1ri_info_regs.sv */
`timescale 1ns/1ps
`include "t1ri_defs.svh"

// Overview of operation
// (R1) flags latch until host reads them
// (R2) read clears flag; level alarms set again
// (R3) mask write refreshes ones, holds zeros
// (R4) flag frame alignment change after resync
// (R5) flag eight or more consecutive zeros
// (R6) flag sixteen or more consecutive zeros
// (R7) flag receive store full and empty slips
// (R8) flag framing bit received in error
// (R9) flag framer sync regained until read
// (R10) flag carrier restored until read
// (R11) flag transmit store full, frame dropped
// (R12) flag transmit store empty, frame repeated
// (R13) transmit slip flag on either slip
// (R14) flag blue alarm clearing until read
// (R15) flag receive pulse density violation
// (R16) flag transmit pulse density violation
// (R17) report receive level as two-bit code
// (R18) flag jitter fifo within four bits
// (R19) flag receive clock idle two microseconds
// (R20) carrier loss after 192 consecutive zeros
// (R21) carrier loss clears on 14 of 112
// (R22) host ignores low three bits, register three
module t1ri_info_regs
#(
	parameter int JA_DEPTH = 32,
	parameter int JA_W     = 8
)
(
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire t1ri_pkg::t1ri_host_t host_req,
	output logic [7:0]                read_data,
	input  wire t1ri_pkg::t1ri_evt_t  evt,
	input  wire logic [1:0]           rx_level,
	input  wire logic [JA_W-1:0]      jitter_fill,
	input  wire logic                 rx_bipolar_pos_in,
	input  wire logic                 rx_bipolar_neg_in,
	input  wire logic                 rx_clock_in
);
	import t1ri_pkg::*;

	logic [7:0] flags1, flags2, flags3;
	logic [7:0] view1, view2, view3;
	logic [7:0] set1, set2, set3;
	logic [7:0] mask1, mask2, mask3;
	logic [2:0] clk_sync;
	logic [1:0] pos_sync, neg_sync;
	logic       clk_edge;
	logic       bit_stb, bit_one;
	logic [7:0] idle_cnt;
	logic       clock_lost;
	logic       jitter_near;
	logic       zero8, zero16, carrier_loss, carrier_back;

	// latched flags: set wins over the clear of a snapshot
	function automatic logic [7:0] next_flags(input logic [7:0] cur,
		input logic [7:0] set, input logic [7:0] clr);
		next_flags = (cur & ~clr) | set;
	endfunction

	// held readable value: masked bits refreshed, others kept
	function automatic logic [7:0] next_view(input logic [7:0] cur,
		input logic [7:0] fresh, input logic [7:0] mask);
		next_view = (cur & ~mask) | (fresh & mask);
	endfunction

	// mask byte for a write to one register address
	function automatic logic [7:0] wr_mask(input t1ri_host_t req,
		input logic [7:0] addr);
		wr_mask = (req.wr && req.addr == addr) ? req.wdata
			: `T1RI_RESET_BYTE;
	endfunction

	assign mask1 = wr_mask(host_req, `T1RI_ADDR_INFO1);
	assign mask2 = wr_mask(host_req, `T1RI_ADDR_INFO2);
	assign mask3 = wr_mask(host_req, `T1RI_ADDR_INFO3);

	// receive clock and bipolar data pins, two-flop synchronisers
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			clk_sync <= 3'h0;
			pos_sync <= 2'h0;
			neg_sync <= 2'h0;
		end
		else
		begin
			clk_sync <= {clk_sync[1:0], rx_clock_in};
			pos_sync <= {pos_sync[0], rx_bipolar_pos_in};
			neg_sync <= {neg_sync[0], rx_bipolar_neg_in};
		end

	// one bit per rising receive clock; a pulse on either rail is a one
	assign clk_edge = clk_sync[1] && !clk_sync[2];
	assign bit_stb  = clk_edge;
	assign bit_one  = pos_sync[1] | neg_sync[1];

	// receive clock idle counter, saturating at the loss threshold
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			idle_cnt   <= 8'h00;
			clock_lost <= 1'b0;
		end
		else
		begin
			if (clk_sync[1] != clk_sync[2])
				idle_cnt <= 8'h00;
			else if (idle_cnt != 8'(`T1RI_RX_CLOCK_LOST_CYC))
				idle_cnt <= idle_cnt + 8'h01;
			clock_lost <= idle_cnt == 8'(`T1RI_RX_CLOCK_LOST_CYC); // (R19)
		end

	// jitter attenuator fill near its limit
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			jitter_near <= 1'b0;
		else
			jitter_near <= jitter_fill >=
				JA_W'(JA_DEPTH - `T1RI_JA_MARGIN); // (R18)

	// zero runs and framer carrier loss
	t1ri_line_mon u_line_mon
	(
		.ref_clk      (ref_clk),
		.rst_n        (rst_n),
		.bit_stb      (bit_stb),
		.bit_one      (bit_one),
		.zero8        (zero8),
		.zero16       (zero16),
		.carrier_loss (carrier_loss),
		.carrier_back (carrier_back)
	);

	// set terms of information register one; bits 2,1 unused
	assign set1 = {
		evt.frame_align_changed, // (R4)
		zero8,                   // (R5)
		zero16,                  // (R6)
		evt.rx_estore_full,      // (R7)
		evt.rx_estore_empty,     // (R7)
		2'b00,
		evt.frame_bit_error      // (R8)
	};

	// set terms of information register two
	assign set2 = {
		evt.sync_regained,                       // (R9)
		carrier_back,                            // (R10)
		evt.tx_estore_full,                      // (R11)
		evt.tx_estore_empty,                     // (R12)
		evt.tx_estore_full | evt.tx_estore_empty, // (R13)
		evt.blue_alarm_cleared,                  // (R14)
		evt.rx_density_violation,                // (R15)
		evt.tx_density_violation                 // (R16)
	};

	// set terms of register three; level alarms keep setting
	assign set3 = {
		rx_level,     // (R17)
		jitter_near,  // (R18)
		clock_lost,   // (R19)
		carrier_loss, // (R20)
		3'b000        // (R22)
	};

	// latched flags, cleared by the snapshot write
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			flags1 <= `T1RI_RESET_BYTE;
			flags2 <= `T1RI_RESET_BYTE;
			flags3 <= `T1RI_RESET_BYTE;
		end
		else
		begin
			flags1 <= next_flags(flags1, set1, mask1); // (R1) (R2)
			flags2 <= next_flags(flags2, set2, mask2); // (R1) (R2)
			flags3 <= next_flags(flags3, set3, mask3); // (R1) (R2)
		end

	// readable copies refreshed under the write mask
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			view1 <= `T1RI_RESET_BYTE;
			view2 <= `T1RI_RESET_BYTE;
			view3 <= `T1RI_RESET_BYTE;
		end
		else
		begin
			view1 <= next_view(view1, flags1, mask1); // (R3)
			view2 <= next_view(view2, flags2, mask2); // (R3)
			view3 <= next_view(view3, flags3, mask3); // (R3)
		end

	// read port: registered byte, zero for other addresses
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			read_data <= `T1RI_RESET_BYTE;
		else if (host_req.rd)
			case (host_req.addr)
			`T1RI_ADDR_INFO1: read_data <= view1;
			`T1RI_ADDR_INFO2: read_data <= view2;
			`T1RI_ADDR_INFO3: read_data <= view3;
			default:          read_data <= `T1RI_UNMAPPED;
			endcase

	// snapshot write to register two carrying a one in bit 7
	sequence snap2_s;
		mask2[`T1RI_I2_SYNC_REGAIN] && !set2[`T1RI_I2_SYNC_REGAIN];
	endsequence

	// snapshot, one idle cycle, then read of register two
	sequence snap_read2_s;
		snap2_s ##1 !host_req.wr
		##1 (host_req.rd && host_req.addr == `T1RI_ADDR_INFO2);
	endsequence

	// latched flag survives until a masked write
	flag_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(flags1[`T1RI_I1_FRAME_ALIGN] &&
		!mask1[`T1RI_I1_FRAME_ALIGN])
		|=> flags1[`T1RI_I1_FRAME_ALIGN]) // (R1)
		else $error("latched flag lost without a read");

	// snapshot moves flag to view and clears it
	flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		snap2_s |=> !flags2[`T1RI_I2_SYNC_REGAIN] &&
		view2[`T1RI_I2_SYNC_REGAIN] == $past(flags2[`T1RI_I2_SYNC_REGAIN]))
		// (R2)
		else $error("snapshot did not move and clear flag");

	// read after snapshot returns the captured bit
	read_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		snap_read2_s |=> read_data[`T1RI_I2_SYNC_REGAIN] ==
		$past(flags2[`T1RI_I2_SYNC_REGAIN], 3)) // (R3)
		else $error("read data not the snapshot");

	// zero mask bits keep the held value
	view_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		host_req.wr |=> (view3 & ~$past(mask3)) ==
		($past(view3) & ~$past(mask3))) // (R3)
		else $error("unmasked view bits changed");

	// framing bit error latches next cycle
	bit_error_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		evt.frame_bit_error |=> flags1[`T1RI_I1_FRAME_BITERR]) // (R8)
		else $error("frame bit error not latched");

	// either transmit slip sets the slip flag
	tx_slip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(evt.tx_estore_full || evt.tx_estore_empty)
		|=> flags2[`T1RI_I2_TX_SLIP]) // (R13)
		else $error("transmit slip flag missed");

	// carrier restore pulse latches
	carrier_back_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carrier_back |=> flags2[`T1RI_I2_CARRIER_BACK]) // (R10)
		else $error("carrier restored not latched");

	// jitter fill near limit latches within two cycles
	jitter_lim_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		jitter_fill >= JA_W'(JA_DEPTH - `T1RI_JA_MARGIN)
		|=> ##1 flags3[`T1RI_I3_JITTER_LIMIT]) // (R18)
		else $error("jitter limit flag missed");

	// idle receive clock at threshold flags loss
	clock_lost_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		idle_cnt == 8'(`T1RI_RX_CLOCK_LOST_CYC)
		|=> ##1 flags3[`T1RI_I3_CLOCK_LOST]) // (R19)
		else $error("receive clock loss flag missed");

	// loss level keeps its flag set past a read
	loss_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		carrier_loss |=> flags3[`T1RI_I3_CARRIER_LOSS]) // (R2) (R20)
		else $error("carrier loss flag not held");

endmodule // t1ri_info_regs

/* hw/t1ri_line_mon.sv */
`timescale 1ns/1ps
`include "t1ri_defs.svh"

module t1ri_line_mon
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic bit_stb,
	input  wire logic bit_one,
	output logic      zero8,
	output logic      zero16,
	output logic      carrier_loss,
	output logic      carrier_back
);
	import t1ri_pkg::*;

	logic [7:0]    zero_run;
	logic [7:0]    win_cnt;
	logic [7:0]    ones_cnt;
	t1ri_carrier_t state;
	logic          loss_hit;
	logic          ones_hit;

	assign loss_hit = bit_stb && !bit_one &&
		zero_run == `T1RI_LOSS_ZEROS - 8'h01;
	assign ones_hit = bit_one && ones_cnt + 8'h01 >= `T1RI_CLEAR_ONES;

	// consecutive zero run, saturating at the loss count
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
			zero_run <= 8'h00;
		else if (bit_stb)
			zero_run <= bit_one ? 8'h00 :
				(zero_run == `T1RI_LOSS_ZEROS ? zero_run
				: zero_run + 8'h01);

	// eight and sixteen zero pulses, once per run
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			zero8  <= 1'b0;
			zero16 <= 1'b0;
		end
		else
		begin
			zero8  <= bit_stb && !bit_one &&
				zero_run == `T1RI_ZERO_SHORT - 8'h01; // (R5)
			zero16 <= bit_stb && !bit_one &&
				zero_run == `T1RI_ZERO_LONG - 8'h01; // (R6)
		end

	// carrier loss: set on zero run, clear by ones in window
	always_ff @(posedge ref_clk or negedge rst_n)
		if (!rst_n)
		begin
			state        <= CL_PRESENT;
			win_cnt      <= 8'h00;
			ones_cnt     <= 8'h00;
			carrier_loss <= 1'b0;
			carrier_back <= 1'b0;
		end
		else
		begin
			carrier_back <= 1'b0;
			case (state)
			CL_PRESENT:
				if (loss_hit)
				begin
					state        <= CL_LOST; // (R20)
					carrier_loss <= 1'b1;
				end
			CL_LOST:
				if (bit_stb && bit_one)
				begin
					state    <= CL_WINDOW; // window opens on first one
					win_cnt  <= 8'h01;
					ones_cnt <= 8'h01;
				end
			CL_WINDOW:
				if (bit_stb)
				begin
					if (ones_hit)
					begin
						state        <= CL_PRESENT; // (R21)
						carrier_loss <= 1'b0;
						carrier_back <= 1'b1;
					end
					else if (win_cnt + 8'h01 >= `T1RI_CLEAR_WINDOW)
						state <= CL_LOST; // window spent, wait again
					win_cnt  <= win_cnt + 8'h01;
					ones_cnt <= ones_cnt + {7'h00, bit_one};
				end
			default:
				state <= CL_PRESENT;
			endcase
		end

	// loss rises one cycle after the 192nd zero strobe
	loss_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(state == CL_PRESENT && loss_hit) |=> carrier_loss) // (R20)
		else $error("carrier loss not set after zero run");

	// a clear only happens with enough ones seen
	loss_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$fell(carrier_loss) |-> $past(ones_hit && bit_stb)) // (R21)
		else $error("carrier loss cleared without ones");

	// sixteen zero pulse follows a run of sixteen
	zero_long_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		zero16 |-> zero_run == `T1RI_ZERO_LONG) // (R6)
		else $error("sixteen zero pulse without run");

endmodule // t1ri_line_mon

/* hw/t1ri_pkg.sv */
package t1ri_pkg;

	// one access on the parallel control port
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} t1ri_host_t;

	// one-cycle event pulses from framer and elastic stores
	typedef struct packed {
		logic frame_align_changed;
		logic rx_estore_full;
		logic rx_estore_empty;
		logic frame_bit_error;
		logic sync_regained;
		logic tx_estore_full;
		logic tx_estore_empty;
		logic blue_alarm_cleared;
		logic rx_density_violation;
		logic tx_density_violation;
	} t1ri_evt_t;

	// carrier loss tracking states
	typedef enum logic [2:0] {
		CL_PRESENT = 3'b001,
		CL_LOST    = 3'b010,
		CL_WINDOW  = 3'b100
	} t1ri_carrier_t;

endpackage
